// ### rtl/scc_pkg.sv
// constants and types shared by the serial channel control/status bank
package scc_pkg;

  // register byte offsets per channel
  localparam logic [7:0]  CTRL_OFS0     = 8'h20;
  localparam logic [7:0]  STAT_OFS0     = 8'h24;
  localparam logic [7:0]  CTRL_OFS1     = 8'h50;
  localparam logic [7:0]  STAT_OFS1     = 8'h54;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK    = 32'h0F3F_FFFF;   // spare bits read zero
  localparam logic [31:0] STICKY_MASK   = 32'h000C_FF00;
  localparam logic [31:0] STICKY_RESET  = 32'h0000_0000;

  // control field positions
  localparam int CB_TX_EN    = 3;
  localparam int CB_RX_EN    = 11;
  localparam int CB_TRIG_EN  = 14;
  localparam int CB_TX_BIST  = 15;
  localparam int CB_OUT_A    = 16;
  localparam int CB_LOAD_PAT = 17;
  localparam int CB_IN_A     = 18;
  localparam int CB_RX_BIST  = 19;
  localparam int CB_TEST     = 20;
  localparam int CB_FORCE_RF = 21;
  localparam int CB_SEND_NOW = 24;
  localparam int CB_RBSEL    = 25;
  localparam int CB_INIT_RF  = 27;

  // readback select codes
  localparam logic [1:0] RBSEL_NORMAL = 2'h0;
  localparam logic [1:0] RBSEL_WDMA   = 2'h1;
  localparam logic [1:0] RBSEL_RDMA   = 2'h2;

  // status field positions
  localparam int SB_TX_EMPTY = 0;
  localparam int SB_TX_AE    = 1;
  localparam int SB_TX_FULL  = 2;
  localparam int SB_TX_DV    = 3;
  localparam int SB_RX_EMPTY = 4;
  localparam int SB_RX_AF    = 5;
  localparam int SB_RX_FULL  = 6;
  localparam int SB_RX_DV    = 7;
  localparam int SB_AE_LAT   = 8;
  localparam int SB_AF_LAT   = 9;
  localparam int SB_OVF_LAT  = 10;
  localparam int SB_SYM_ERR  = 11;
  localparam int SB_WDMA_DONE = 12;
  localparam int SB_RDMA_DONE = 13;
  localparam int SB_WDMA_ERR = 14;
  localparam int SB_RDMA_ERR = 15;
  localparam int SB_WDMA_IDLE = 16;
  localparam int SB_RDMA_IDLE = 17;
  localparam int SB_RX_RDY   = 18;
  localparam int SB_TX_READ  = 19;

  // framing symbols and format entries
  localparam logic [2:0][7:0] START_SEQ = {8'h7C, 8'h3C, 8'hBC};  // sent index 0 first
  localparam logic [7:0]  STOP_CODE     = 8'hFE;
  localparam logic [8:0]  FMT_NULL      = 9'h000;
  localparam int          FMT_DATA_BIT  = 8;
  localparam logic [1:0]  START_LAST    = 2'h2;

  // framer violation window
  localparam logic [5:0]  WIN_LAST      = 6'h3F;   // 64 received bytes
  localparam logic [4:0]  VIOL_LIMIT    = 5'h10;   // sixteen violations

  // one transmitted or received symbol
  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } scc_sym_s;

  // FIFO and pipeline flags from the data path
  typedef struct packed {
    logic       tx_empty;
    logic       tx_full;
    logic       rx_empty;
    logic       rx_full;
    logic       tx_stage_valid;
    logic [2:0] rx_stage_count;
  } scc_fifo_flags_s;

endpackage

// ### rtl/scc_channel.sv
// per-channel control and status bank with transmit/receive framing logic
module scc_channel #(
  parameter int CHANNEL = 0,      // selects register offsets
  parameter int CNT_W   = 16,     // FIFO count and threshold width
  parameter int WC_W    = 32      // DMA word counter width
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // register port
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [31:0]            i_reg_wdata,
  output logic      [31:0]            o_reg_rdata,
  output logic                        o_reg_rvalid,
  // FIFO levels and thresholds
  input  wire logic [CNT_W-1:0]       i_tx_count,
  input  wire logic [CNT_W-1:0]       i_rx_count,
  input  wire logic [CNT_W-1:0]       i_tx_almost_empty_threshold,
  input  wire logic [CNT_W-1:0]       i_rx_almost_full_threshold,
  input  wire scc_pkg::scc_fifo_flags_s i_flags,
  // transmit FIFO head and format memory
  input  wire logic [7:0]             i_txf_byte,
  output logic                        o_txf_pop,
  output logic      [6:0]             o_tfmt_addr,
  input  wire logic [8:0]             i_tfmt_entry,
  output logic      [6:0]             o_rfmt_addr,
  input  wire logic [8:0]             i_rfmt_entry,
  // serial transmitter
  output scc_pkg::scc_sym_s           o_tx_sym,
  output logic                        o_tx_valid,
  input  wire logic                   i_tx_ready,
  input  wire logic                   i_tx_data_read,
  output logic                        o_tx_out_a_en,
  output logic                        o_tx_bist,
  output logic                        o_tx_load_pattern,
  // serial receiver
  input  wire logic                   i_rx_valid,
  input  wire scc_pkg::scc_sym_s      i_rx_sym,
  input  wire logic                   i_rx_violation_symbol,
  input  wire logic                   i_rx_ready,
  output logic                        o_rx_sel_a,
  output logic                        o_rx_bist,
  output logic                        o_reframe_request,
  // receive FIFO write
  output logic                        o_rxf_write,
  output logic      [7:0]             o_rxf_byte,
  // trigger and DMA engine
  input  wire logic                   i_ttl_trigger,
  input  wire logic                   i_wdma_start,
  input  wire logic                   i_wdma_word,
  input  wire logic                   i_wdma_busy,
  input  wire logic                   i_wdma_error,
  input  wire logic                   i_rdma_start,
  input  wire logic                   i_rdma_word,
  input  wire logic                   i_rdma_busy,
  input  wire logic                   i_rdma_error
);

  typedef enum logic [2:0] {
    SCC_TX_IDLE  = 3'b000,
    SCC_TX_START = 3'b001,
    SCC_TX_DATA  = 3'b010,
    SCC_TX_STOP  = 3'b011,
    SCC_TX_FMT   = 3'b100
  } scc_tx_state_e;

  typedef enum logic [0:0] {
    SCC_RX_HUNT = 1'b0,
    SCC_RX_DATA = 1'b1
  } scc_rx_state_e;

  // register decode
  wire logic [7:0]  ctrl_ofs  = (CHANNEL == 0) ? scc_pkg::CTRL_OFS0 : scc_pkg::CTRL_OFS1;
  wire logic [7:0]  stat_ofs  = (CHANNEL == 0) ? scc_pkg::STAT_OFS0 : scc_pkg::STAT_OFS1;
  wire logic        ctrl_hit  = (i_reg_addr == ctrl_ofs);
  wire logic        stat_hit  = (i_reg_addr == stat_ofs);
  wire logic        ctrl_wr   = i_reg_wr && ctrl_hit;
  wire logic        stat_wr   = i_reg_wr && stat_hit;

  logic [31:0]      ctrl;             // control register
  logic [31:0]      sticky;           // latched status bits
  logic [WC_W-1:0]  wdma_words;       // words moved by last write DMA
  logic [WC_W-1:0]  rdma_words;       // words moved by last read DMA
  logic             wdma_busy_q;      // previous busy, for completion edge
  logic             rdma_busy_q;
  logic             ae_q;             // previous at-or-below-threshold transmit level (tx_le)
  logic             af_q;             // previous almost-full level
  logic             init_rf_pulse;    // one cycle after a write with initiate set

  // pin synchronisers: stage 1 is read only by stage 2
  logic [2:0]       pin_s1;
  logic [2:0]       pin_s2;
  wire logic        viol_s   = pin_s2[0];
  wire logic        rx_rdy_s = pin_s2[1];
  wire logic        tx_rd_s  = pin_s2[2];

  // control fields
  wire logic        tx_en    = ctrl[scc_pkg::CB_TX_EN];
  wire logic        rx_en    = ctrl[scc_pkg::CB_RX_EN];
  wire logic        test_md  = ctrl[scc_pkg::CB_TEST];
  wire logic [1:0]  rb_sel   = ctrl[scc_pkg::CB_RBSEL +: 2];

  // live status terms
  wire logic        tx_ae    = (i_tx_count < i_tx_almost_empty_threshold);
  wire logic        tx_le    = (i_tx_count <= i_tx_almost_empty_threshold);
  wire logic        rx_af    = (i_rx_count >= i_rx_almost_full_threshold);
  wire logic        tx_dv    = !i_flags.tx_empty || i_flags.tx_stage_valid;
  wire logic        rx_dv    = !i_flags.rx_empty || (i_flags.rx_stage_count != 3'h0);

  // transmit buffer: two entries, head drives the pins
  scc_pkg::scc_sym_s buf1;            // second entry
  logic              buf1_v;
  wire logic         can_push = !buf1_v;
  wire logic         buf_pop  = o_tx_valid && i_tx_ready;

  // transmit sequencer state
  scc_tx_state_e tx_state;
  scc_tx_state_e next_tx_state;
  logic [1:0]    tx_idx;
  logic [1:0]    next_tx_idx;
  logic [6:0]    next_tfmt_addr;
  logic          pop_wait;            // FIFO head settling after a pop
  logic          push_v;
  scc_pkg::scc_sym_s push_sym;
  logic          pop_req;

  // receive framing state
  scc_rx_state_e rx_state;
  scc_rx_state_e next_rx_state;
  logic [1:0]    rx_idx;
  logic [1:0]    next_rx_idx;
  logic [6:0]    next_rfmt_addr;
  logic          rx_wr_v;

  // framer violation counting
  logic [5:0]    win_cnt;
  logic [4:0]    viol_cnt;
  wire logic     viol_hit  = i_rx_valid && viol_s;
  wire logic [4:0] viol_next = viol_hit ? viol_cnt + 5'h01 : viol_cnt;
  wire logic     viol_trip = i_rx_valid && (viol_next >= scc_pkg::VIOL_LIMIT);

  // frame launch: both modes need data; immediate goes at once, else trigger mode waits for the trigger
  wire logic     byte_ok = !i_flags.tx_empty && !pop_wait;
  wire logic     tx_go   = tx_en && !i_flags.tx_empty &&
                           (ctrl[scc_pkg::CB_SEND_NOW] ||
                            (ctrl[scc_pkg::CB_TRIG_EN] && i_ttl_trigger));

  // sticky set vector; completion is the falling edge of busy
  wire logic [31:0] sticky_set = {
    12'h000,
    tx_rd_s,
    rx_rdy_s,
    2'h0,
    i_rdma_error,
    i_wdma_error,
    rdma_busy_q && !i_rdma_busy,
    wdma_busy_q && !i_wdma_busy,
    viol_s,
    rx_wr_v && i_flags.rx_full,
    rx_af && !af_q,
    tx_le && !ae_q,
    8'h00
  };
  wire logic [31:0] sticky_clr = stat_wr ? (i_reg_wdata & scc_pkg::STICKY_MASK) : 32'h0000_0000;

  // status word: live bits beside the latched ones
  wire logic [31:0] status_word = sticky | {
    14'h0000,
    !rdma_busy_q, !wdma_busy_q,
    8'h00,
    rx_dv, i_flags.rx_full, rx_af, i_flags.rx_empty,
    tx_dv, i_flags.tx_full, tx_ae, i_flags.tx_empty
  };

  // control readback, with DMA word counts selected by the readback field
  wire logic [31:0] ctrl_rb =
    (rb_sel == scc_pkg::RBSEL_WDMA) ? 32'(wdma_words) :
    (rb_sel == scc_pkg::RBSEL_RDMA) ? 32'(rdma_words) : ctrl;
  wire logic [31:0] rd_mux = ctrl_hit ? ctrl_rb : (stat_hit ? status_word : 32'h0000_0000);

  // control register, reframe pulse and readback
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl          <= scc_pkg::CTRL_RESET;
      init_rf_pulse <= 1'b0;
      o_reg_rdata   <= 32'h0000_0000;
      o_reg_rvalid  <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl <= i_reg_wdata & scc_pkg::CTRL_WMASK;
      end
      init_rf_pulse <= ctrl_wr && i_reg_wdata[scc_pkg::CB_INIT_RF];
      o_reg_rdata   <= i_reg_rd ? rd_mux : 32'h0000_0000;
      o_reg_rvalid  <= i_reg_rd;
    end
  end

  // latched status: a set in the clearing cycle wins
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sticky      <= scc_pkg::STICKY_RESET;
      wdma_busy_q <= 1'b0;
      rdma_busy_q <= 1'b0;
      ae_q        <= 1'b0;
      af_q        <= 1'b0;
    end else begin
      sticky      <= (sticky & ~sticky_clr) | (sticky_set & scc_pkg::STICKY_MASK);
      wdma_busy_q <= i_wdma_busy;
      rdma_busy_q <= i_rdma_busy;
      ae_q        <= tx_le;
      af_q        <= rx_af;
    end
  end

  // DMA word counters, cleared by the start of a DMA of their kind
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wdma_words <= '0;
      rdma_words <= '0;
    end else begin
      if (i_wdma_start) begin
        wdma_words <= '0;
      end else if (i_wdma_word) begin
        wdma_words <= wdma_words + WC_W'(1);
      end
      if (i_rdma_start) begin
        rdma_words <= '0;
      end else if (i_rdma_word) begin
        rdma_words <= rdma_words + WC_W'(1);
      end
    end
  end

  // two-flop synchronisers for the transceiver pins
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {i_tx_data_read, i_rx_ready, i_rx_violation_symbol};
      pin_s2 <= pin_s1;
    end
  end

  // path and test controls straight from the register
  assign o_tx_out_a_en     = ctrl[scc_pkg::CB_OUT_A];
  assign o_tx_bist         = ctrl[scc_pkg::CB_TX_BIST];
  assign o_tx_load_pattern = ctrl[scc_pkg::CB_LOAD_PAT];
  assign o_rx_sel_a        = ctrl[scc_pkg::CB_IN_A];
  assign o_rx_bist         = ctrl[scc_pkg::CB_RX_BIST];

  // framer: count violations per 64-byte window, request reframe
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      win_cnt           <= 6'h00;
      viol_cnt          <= 5'h00;
      o_reframe_request <= 1'b0;
    end else begin
      if (viol_trip || (i_rx_valid && win_cnt == scc_pkg::WIN_LAST)) begin
        win_cnt  <= 6'h00;
        viol_cnt <= 5'h00;
      end else if (i_rx_valid) begin
        win_cnt  <= win_cnt + 6'h01;
        viol_cnt <= viol_next;
      end
      // forced request stays high; the receiver handles long requests itself
      o_reframe_request <= ctrl[scc_pkg::CB_FORCE_RF] || init_rf_pulse || viol_trip;
    end
  end

  // transmit sequencer
  always_comb begin
    next_tx_state  = tx_state;
    next_tx_idx    = tx_idx;
    next_tfmt_addr = o_tfmt_addr;
    push_v         = 1'b0;
    push_sym       = '{ctrl: 1'b0, data: i_txf_byte};
    pop_req        = 1'b0;
    unique case (tx_state)
      SCC_TX_IDLE: begin
        next_tx_idx    = 2'h0;
        next_tfmt_addr = 7'h00;
        if (tx_go) begin
          next_tx_state = test_md ? SCC_TX_START : SCC_TX_FMT;
        end
      end
      SCC_TX_START: begin
        if (can_push) begin
          push_v   = 1'b1;
          push_sym = '{ctrl: 1'b1, data: scc_pkg::START_SEQ[tx_idx]};
          next_tx_idx = tx_idx + 2'h1;
          if (tx_idx == scc_pkg::START_LAST) begin
            next_tx_state = SCC_TX_DATA;
          end
        end
      end
      SCC_TX_DATA: begin
        if (can_push && byte_ok) begin
          push_v  = 1'b1;
          pop_req = 1'b1;
        end else if (i_flags.tx_empty && !pop_wait) begin
          next_tx_state = SCC_TX_STOP;
        end
      end
      SCC_TX_STOP: begin
        if (can_push) begin
          push_v        = 1'b1;
          push_sym      = '{ctrl: 1'b1, data: scc_pkg::STOP_CODE};
          next_tx_state = SCC_TX_IDLE;
        end
      end
      SCC_TX_FMT: begin
        if (i_tfmt_entry == scc_pkg::FMT_NULL) begin
          next_tx_state = SCC_TX_IDLE;
        end else if (can_push && i_tfmt_entry[scc_pkg::FMT_DATA_BIT]) begin
          if (byte_ok) begin
            push_v         = 1'b1;
            pop_req        = 1'b1;
            next_tfmt_addr = o_tfmt_addr + 7'h01;
          end
        end else if (can_push) begin
          push_v         = 1'b1;
          push_sym       = '{ctrl: 1'b1, data: i_tfmt_entry[7:0]};
          next_tfmt_addr = o_tfmt_addr + 7'h01;
        end
      end
      default: begin
        next_tx_state = SCC_TX_IDLE;
      end
    endcase
    // disabling the transmitter abandons the frame
    if (!tx_en) begin
      next_tx_state = SCC_TX_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tx_state    <= SCC_TX_IDLE;
      tx_idx      <= 2'h0;
      o_tfmt_addr <= 7'h00;
      o_txf_pop   <= 1'b0;
      pop_wait    <= 1'b0;
    end else begin
      tx_state    <= next_tx_state;
      tx_idx      <= next_tx_idx;
      o_tfmt_addr <= next_tfmt_addr;
      o_txf_pop   <= pop_req;
      pop_wait    <= pop_req;   // the head is stale until the pop lands
    end
  end

  // two-entry transmit buffer: a stalled transmitter loses no symbol
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_tx_sym   <= '0;
      o_tx_valid <= 1'b0;
      buf1       <= '0;
      buf1_v     <= 1'b0;
    end else if (buf_pop) begin
      o_tx_sym   <= buf1_v ? buf1 : push_sym;
      o_tx_valid <= buf1_v || push_v;
      if (buf1_v) begin
        buf1_v <= 1'b0;   // no push while the second entry is full
      end
    end else if (push_v && !o_tx_valid) begin
      o_tx_sym   <= push_sym;
      o_tx_valid <= 1'b1;
    end else if (push_v) begin
      buf1   <= push_sym;
      buf1_v <= 1'b1;
    end
  end

  // receive framing: start hunt in test mode, format check otherwise
  always_comb begin
    next_rx_state  = rx_state;
    next_rx_idx    = rx_idx;
    next_rfmt_addr = o_rfmt_addr;
    rx_wr_v        = 1'b0;
    if (!rx_en) begin
      next_rx_state  = SCC_RX_HUNT;
      next_rx_idx    = 2'h0;
      next_rfmt_addr = 7'h00;
    end else if (test_md) begin
      if (i_rx_valid) begin
        unique case (rx_state)
          SCC_RX_HUNT: begin
            if (i_rx_sym.ctrl && i_rx_sym.data == scc_pkg::START_SEQ[rx_idx]) begin
              next_rx_idx = rx_idx + 2'h1;
              if (rx_idx == scc_pkg::START_LAST) begin
                next_rx_state = SCC_RX_DATA;
                next_rx_idx   = 2'h0;
              end
            end else begin
              next_rx_idx = 2'h0;
            end
          end
          SCC_RX_DATA: begin
            if (!i_rx_sym.ctrl) begin
              rx_wr_v = 1'b1;
            end else begin
              next_rx_state = SCC_RX_HUNT;   // stop or stray control ends the frame
            end
          end
        endcase
      end
    end else if (i_rfmt_entry == scc_pkg::FMT_NULL) begin
      next_rfmt_addr = 7'h00;
    end else if (i_rx_valid) begin
      if (i_rfmt_entry[scc_pkg::FMT_DATA_BIT]) begin
        rx_wr_v        = !i_rx_sym.ctrl;
        next_rfmt_addr = i_rx_sym.ctrl ? 7'h00 : o_rfmt_addr + 7'h01;
      end else if (i_rx_sym.ctrl && i_rx_sym.data == i_rfmt_entry[7:0]) begin
        next_rfmt_addr = o_rfmt_addr + 7'h01;
      end else begin
        next_rfmt_addr = 7'h00;   // format mismatch: resynchronise at the first entry
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_state    <= SCC_RX_HUNT;
      rx_idx      <= 2'h0;
      o_rfmt_addr <= 7'h00;
      o_rxf_write <= 1'b0;
      o_rxf_byte  <= 8'h00;
    end else begin
      rx_state    <= next_rx_state;
      rx_idx      <= next_rx_idx;
      o_rfmt_addr <= next_rfmt_addr;
      o_rxf_write <= rx_wr_v;
      o_rxf_byte  <= i_rx_sym.data;
    end
  end

endmodule

// ### verification/scc_asserts.sv
// assertion checker for the channel 0 control and status bank
module scc_asserts (
  input wire logic i_clk, i_resetn, i_reg_wr, i_reg_rd, o_reg_rvalid, o_tx_out_a_en, o_rx_sel_a, o_reframe_request,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata, o_reg_rdata,
  input wire scc_pkg::scc_fifo_flags_s i_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire logic cw = i_reg_wr && i_reg_addr == scc_pkg::CTRL_OFS0;  // control write
  wire logic sr = i_reg_rd && i_reg_addr == scc_pkg::STAT_OFS0;  // status read
  wire logic hit = i_reg_addr == scc_pkg::CTRL_OFS0 || i_reg_addr == scc_pkg::STAT_OFS0;
  // control write with bit b, then two quiet cycles so the level has landed
  sequence s_cw(b);
    cw && b ##1 !cw [*2];
  endsequence
  a_out_a_follow: assert property (s_cw(1'b1) |-> o_tx_out_a_en == $past(i_reg_wdata[16], 2))
    else $error("output A enable differs from control");
  a_in_sel_follow: assert property (s_cw(1'b1) |-> o_rx_sel_a == $past(i_reg_wdata[18], 2))
    else $error("input select differs from control");
  a_force_reframe: assert property (s_cw(i_reg_wdata[21]) |-> o_reframe_request)
    else $error("forced reframe not held");
  a_init_reframe: assert property (cw && i_reg_wdata[27] |-> ##[1:2] o_reframe_request)
    else $error("initiated reframe missing");
  a_read_answer: assert property (o_reg_rvalid == $past(i_reg_rd))
    else $error("read answer not one cycle after request");
  a_unmapped_zero: assert property (i_reg_rd && !hit |=> o_reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_status_spare: assert property (sr |=> o_reg_rdata[31:20] == 12'h000)
    else $error("status spare bits set");
  a_fifo_flags: assert property (sr |=> {o_reg_rdata[6], o_reg_rdata[4], o_reg_rdata[2], o_reg_rdata[0]}
    == $past({i_flags.rx_full, i_flags.rx_empty, i_flags.tx_full, i_flags.tx_empty}))
    else $error("FIFO empty or full status wrong");
endmodule

bind scc_channel scc_asserts u_chk (.i_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .o_reg_rvalid, .o_tx_out_a_en,
  .o_rx_sel_a, .o_reframe_request, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_flags);

// ### verification/scc_xcvr_model.sv
// serial transmitter and receiver pair, receiver fed from output C
module scc_xcvr_model (
  input wire logic i_clk, i_valid, i_sel_a, i_tx_bist, i_rx_bist, i_slow, i_viol_req,
  input wire scc_pkg::scc_sym_s i_sym,
  output logic o_ready = 1'b1, o_data_read = 1'b0, o_rx_valid = 1'b0, o_viol = 1'b0, o_rx_ready = 1'b0,
  output scc_pkg::scc_sym_s o_rx_sym = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;  // stall pattern
  wire logic take = i_valid && o_ready;  // symbol taken at this edge
  always @(posedge i_clk) begin
    cnt <= cnt + 3'h1;
    o_ready <= !(i_slow && (cnt[0] ^ cnt[2]));  // slow mode stalls half the cycles
    o_rx_valid <= take && !i_sel_a;
    o_rx_sym <= take && !i_sel_a ? i_sym : ~o_rx_sym;  // idle bus never holds the last symbol
    o_data_read <= take && i_tx_bist && i_sym == {1'b1, scc_pkg::STOP_CODE};
    o_rx_ready <= o_rx_valid && i_rx_bist && o_rx_sym == {1'b1, scc_pkg::STOP_CODE};
    o_viol <= i_viol_req;
  end
endmodule

// ### verification/scc_channel_test.sv
// bench: register reads, sticky status, a test frame looped through the model
module scc_channel_test;
  timeunit 1ns;
  timeprecision 1ps;
  // inputs carry the port names so the instance connects by name
  logic i_clk = '0, i_resetn = '0, i_reg_wr = '0, i_reg_rd = '0, i_ttl_trigger = '0, viol = '0, slow = '0;
  logic i_wdma_start = '0, i_wdma_word = '0, i_wdma_busy = '0, i_wdma_error = '0;
  logic i_rdma_start = '0, i_rdma_word = '0, i_rdma_busy = '0, i_rdma_error = '0;
  logic [7:0] i_reg_addr = 8'h00, i_txf_byte = 8'h00, o_rxf_byte;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata;
  logic [15:0] i_tx_count, i_rx_count, i_tx_almost_empty_threshold, i_rx_almost_full_threshold;
  scc_pkg::scc_fifo_flags_s i_flags = 8'hA0;  // both FIFOs empty
  logic [6:0] o_tfmt_addr, o_rfmt_addr;
  wire logic [8:0] i_tfmt_entry = o_tfmt_addr < 7'h3 ? {o_tfmt_addr[0], 8'h5A} : scc_pkg::FMT_NULL;
  wire logic [8:0] i_rfmt_entry = o_rfmt_addr < 7'h3 ? {o_rfmt_addr[0], 8'h5A} : scc_pkg::FMT_NULL;
  logic o_reg_rvalid, o_txf_pop, o_tx_valid, o_tx_out_a_en, o_tx_bist, o_tx_load_pattern, o_rx_sel_a, o_rx_bist;
  logic o_reframe_request, o_rxf_write, i_tx_ready, i_tx_data_read, i_rx_valid, i_rx_violation_symbol, i_rx_ready;
  scc_pkg::scc_sym_s o_tx_sym, i_rx_sym;
  logic [63:0] notes[$], nt;  // {expected, mask} per read
  logic [7:0] sent[$], txq[$], rxq[$];
  logic [8:0] sq[$];  // symbols the transmitter took
  int n_fail = 0, checked = 0, k;
  scc_channel uut (.*);
  scc_xcvr_model u_xcvr (.i_clk, .i_sym(o_tx_sym), .i_valid(o_tx_valid), .i_sel_a(o_rx_sel_a),
    .i_tx_bist(o_tx_bist), .i_rx_bist(o_rx_bist), .i_slow(slow), .i_viol_req(viol), .o_ready(i_tx_ready),
    .o_data_read(i_tx_data_read), .o_rx_valid(i_rx_valid), .o_rx_sym(i_rx_sym),
    .o_viol(i_rx_violation_symbol), .o_rx_ready(i_rx_ready));
  always #12.5 i_clk = ~i_clk;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp({24'h0, got}, {24'h0, exp});
  endtask
  // strobes drop then idle one edge, so back-to-back calls never reassign in one step
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    tick();
    i_reg_wr = 1'b0;
    tick();
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({e & m, m});
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    tick();
    i_reg_rd = 1'b0;
    tick();
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  task automatic levels(input logic [15:0] tc, ta, rc, ra);
    {i_tx_count, i_tx_almost_empty_threshold, i_rx_count, i_rx_almost_full_threshold} = {tc, ta, rc, ra};
  endtask
  // live status bits expected from the present inputs
  function automatic logic [31:0] live();
    live = {14'h0, !i_rdma_busy, !i_wdma_busy, 8'h00, !i_flags.rx_empty || i_flags.rx_stage_count != 3'h0,
      i_flags.rx_full, i_rx_count >= i_rx_almost_full_threshold, i_flags.rx_empty,
      !i_flags.tx_empty || i_flags.tx_stage_valid, i_flags.tx_full, i_tx_count < i_tx_almost_empty_threshold,
      i_flags.tx_empty};
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // monitor: oldest note against each answer, received bytes, taken symbols
  always @(negedge i_clk) begin
    if (o_reg_rvalid) begin
      nt = notes.pop_front();
      cmp(o_reg_rdata & nt[31:0], nt[63:32]);
    end
    if (o_rxf_write) cmp_byte(o_rxf_byte, rxq.pop_front());
    if (o_tx_valid && i_tx_ready) sq.push_back(o_tx_sym);
  end
  // transmit FIFO head follows each pop; an empty head shows a changing value
  always @(posedge i_clk) if (o_txf_pop) begin
    #1;
    void'(txq.pop_front());
    i_flags.tx_empty = txq.size() == 0;
    i_txf_byte = txq.size() != 0 ? txq[0] : ~i_txf_byte;
  end
  initial begin
    levels(16'h1, 16'h0, 16'h0, 16'hFFFF);
    k = $urandom(26773);
    tick(20);
    i_resetn = 1'b1;
    tick(2);
    rreg(scc_pkg::CTRL_OFS0, 32'h0, 32'hFFFF_FFFF);
    rreg(scc_pkg::STAT_OFS0, live(), 32'hFFFF_FFFF);
    rreg(8'h28, 32'h0, 32'hFFFF_FFFF);
    repeat (8) begin
      {i_wdma_busy, i_rdma_busy} = 2'($urandom);
      tick();
      i_flags = 8'($urandom);
      levels(16'($urandom_range(0, 3)), 16'($urandom_range(0, 3)), 16'($urandom_range(0, 3)), 16'h2);
      rreg(scc_pkg::STAT_OFS0, live(), 32'h0003_00FF);
    end
    {i_wdma_busy, i_rdma_busy} = 2'h0;
    levels(16'h1, 16'h0, 16'h0, 16'hFFFF);
    for (int i = 0; i < 5; i++) sent.push_back(8'($urandom));
    txq = sent;
    rxq = sent;
    i_txf_byte = sent[0];
    i_flags = 8'h10;  // data to send, receive FIFO full
    tick(3);
    wreg(scc_pkg::STAT_OFS0, scc_pkg::STICKY_MASK);
    slow = 1'b1;
    wreg(scc_pkg::CTRL_OFS0, 32'h011B_8808);
    rreg(scc_pkg::CTRL_OFS0, 32'h011B_8808, 32'hFFFF_FFFF);
    cmp(32'({o_tx_bist, o_tx_load_pattern, o_rx_bist}), 32'h7);
    for (k = 0; k < 600 && sq.size() < 9; k++) tick();
    if (sq.size() < 9) begin
      n_fail++;
      print_verdict();
    end
    tick(8);
    for (int i = 0; i < 3; i++) cmp(32'(sq[i]), {23'h0, 1'b1, scc_pkg::START_SEQ[i]});
    cmp(32'(sq[8]), {23'h0, 1'b1, scc_pkg::STOP_CODE});
    cmp(32'(rxq.size()), 32'h0);
    wreg(scc_pkg::CTRL_OFS0, 32'h0100_0808);
    sent = {8'($urandom)};
    txq = sent;
    rxq = sent;
    i_txf_byte = sent[0];
    sq.delete();
    i_flags.tx_empty = 1'b0;
    tick(40);
    cmp(32'(sq.size()), 32'h3);
    cmp(32'({sq[0], sq[1], sq[2]}), {5'h0, 9'h15A, 1'b0, sent[0], 9'h15A});
    cmp(32'(rxq.size()), 32'h0);
    wreg(scc_pkg::CTRL_OFS0, 32'h0);
    i_flags = 8'hA0;
    levels(16'h0, 16'h0, 16'hFFFF, 16'hFFFF);
    viol = 1'b1;
    pulse(i_wdma_busy);
    pulse(i_rdma_busy);
    pulse(i_wdma_error);
    pulse(i_rdma_error);
    viol = 1'b0;
    levels(16'h1, 16'h0, 16'h0, 16'hFFFF);
    tick(4);
    rreg(scc_pkg::STAT_OFS0, 32'h000C_FF00, 32'h000C_FF00);
    wreg(scc_pkg::STAT_OFS0, 32'h0);
    rreg(scc_pkg::STAT_OFS0, 32'h000C_FF00, 32'h000C_FF00);
    wreg(scc_pkg::STAT_OFS0, 32'h0004_5500);
    rreg(scc_pkg::STAT_OFS0, 32'h0008_AA00, 32'h000C_FF00);
    pulse(i_wdma_word);
    pulse(i_rdma_word);
    pulse(i_wdma_start);
    repeat (3) pulse(i_wdma_word);
    pulse(i_rdma_start);
    pulse(i_rdma_word);
    wreg(scc_pkg::CTRL_OFS0, 32'h0224_0000);
    tick(2);
    rreg(scc_pkg::CTRL_OFS0, 32'h3, 32'hFFFF_FFFF);
    wreg(scc_pkg::CTRL_OFS0, 32'h0C00_0000);
    rreg(scc_pkg::CTRL_OFS0, 32'h1, 32'hFFFF_FFFF);
    tick(4);
    print_verdict();
  end
endmodule
